// >>> timer_pkg.sv
// Package for the 8-bit timer compare and flag block.
// Assumes a single clock domain and an 8-bit I/O register bus.
package timer_pkg;
  // Data-space offsets of the registers
  localparam logic [7:0] IO_BIAS = 8'h20;
  localparam logic [7:0] IO_TOP = 8'h3F;
  localparam logic [7:0] FLAGS_OFS = 8'h35;
  localparam logic [7:0] COUNT_OFS = 8'h46;
  localparam logic [7:0] CMPA_OFS = 8'h47;
  localparam logic [7:0] CMPB_OFS = 8'h48;
  localparam logic [7:0] MASK_OFS = 8'h6E;
  localparam logic [7:0] CLKSEL_OFS = 8'h45;
  // Flag and enable bit positions
  localparam int OVF_BIT = 0;
  localparam int CMPA_BIT = 1;
  localparam int CMPB_BIT = 2;
  // Counter limits and reset values
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [7:0] MAX_VAL = 8'hFF;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  // Prescaler: largest division is 1024, counter is 10 bits
  localparam int PRESC_W = 10;

  // Clock select codes
  typedef enum logic [2:0] {
    CS_STOP = 3'b000,
    CS_DIV1 = 3'b001,
    CS_DIV8 = 3'b010,
    CS_DIV64 = 3'b011,
    CS_DIV256 = 3'b100,
    CS_DIV1024 = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } clk_sel_t;

  // One register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic io_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  // Vector acknowledge from the core
  typedef struct packed {
    logic cmpb;
    logic cmpa;
    logic ovf;
  } irq_set_t;

  // Map an access to its data-space offset
  function automatic logic [7:0] data_addr(input logic io_space,
                                           input logic [7:0] addr);
    return io_space ? 8'(addr + IO_BIAS) : addr;
  endfunction
endpackage

// >>> timer_tick.sv
// Timer clock generator: prescaler taps and external pin edge detect.
// Assumes the external count pin is already synchronous to clk_sys.
`timescale 1ns/1ns
module timer_tick
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control
  input wire logic [2:0] clk_sel,
  input wire logic ext_pin,
  // Tick out
  output logic tick
);
  logic [timer_pkg::PRESC_W-1:0] presc_reg, presc_next;
  logic pin_reg, pin_next;
  logic tick_c;

  // Free running prescaler and pin history
  always_comb
  begin
    presc_next = presc_reg + 1'b1;
    pin_next = ext_pin;
  end

  // Select source; stopped when the field is zero
  always_comb
  begin
    case (timer_pkg::clk_sel_t'(clk_sel))
      timer_pkg::CS_STOP: tick_c = 1'b0;
      timer_pkg::CS_DIV1: tick_c = 1'b1;
      timer_pkg::CS_DIV8: tick_c = presc_reg[2:0] == 3'h7;
      timer_pkg::CS_DIV64: tick_c = presc_reg[5:0] == 6'h3F;
      timer_pkg::CS_DIV256: tick_c = presc_reg[7:0] == 8'hFF;
      timer_pkg::CS_DIV1024: tick_c = presc_reg == 10'h3FF;
      timer_pkg::CS_EXT_FALL: tick_c = pin_reg & ~ext_pin;
      timer_pkg::CS_EXT_RISE: tick_c = ~pin_reg & ext_pin;
      default: tick_c = 1'b0;
    endcase
  end

  // Register state
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      presc_reg <= '0;
      pin_reg <= 1'b0;
    end
    else
    begin
      presc_reg <= presc_next;
      pin_reg <= pin_next;
    end
  end

  assign tick = tick_c;
endmodule // timer_tick

// >>> compare_unit.sv
// One compare channel: equality against the counter on each tick.
// Assumes tick and suppress are single-cycle qualifiers from the top.
`timescale 1ns/1ns
module compare_unit
#(
  parameter int WIDTH = 8
)
(
  // Operands
  input wire logic [WIDTH-1:0] count,
  input wire logic [WIDTH-1:0] compare,
  // Qualifiers
  input wire logic tick,
  input wire logic suppress,
  // Match event
  output logic match
);
  // Compared at every timer tick unless a counter write blocks it
  assign match = tick & ~suppress & (count == compare);
endmodule // compare_unit

// >>> timer_core.sv
// Top of the 8-bit timer compare and flag block with its registers.
// Assumes the core issues one-cycle rd/wr strobes; read data is
// registered and valid the cycle after the read strobe.
//
// Behaviour
// - Counter is readable and writable; write loads it
// - Counter write blocks compare on next tick
// - Compare A checked against counter every tick
// - Compare B checked against counter every tick
// - Compare B match sets flag bit 2
// - Compare B vector entry clears its flag
// - Writing one clears compare B flag
// - Compare B request needs global, enable, flag
// - Compare A match sets flag bit 1
// - Compare A flag cleared by vector or one
// - Compare A request needs global, enable, flag
// - Overflow sets flag bit 0
// - Overflow flag cleared by one or vector
// - Overflow request needs global, enable, flag
// - Zero is the bottom of the count
// - 0xFF is the counter maximum
// - Decode data offsets, or I/O offset plus 0x20
// - Mask register enables each interrupt separately
// - Clock select zero stops; others pick sources
`timescale 1ns/1ns
module timer_core
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register bus
  input wire timer_pkg::bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  // Interrupt handshake with the core
  input wire logic global_irq_enable,
  input wire timer_pkg::irq_set_t vector_taken,
  output timer_pkg::irq_set_t irq_request,
  // Pins
  input wire logic external_count_pin,
  output logic compare_a_output_pin,
  output logic compare_b_output_pin
);
  logic [WIDTH-1:0] counter_value_reg, counter_value_next;
  logic [WIDTH-1:0] compare_a_value_reg, compare_a_value_next;
  logic [WIDTH-1:0] compare_b_value_reg, compare_b_value_next;
  logic [2:0] timer_event_flags_reg, timer_event_flags_next;
  logic [2:0] timer_irq_mask_register_reg, timer_irq_mask_register_next;
  logic [2:0] clock_select_field_reg, clock_select_field_next;
  logic block_reg, block_next;
  logic [7:0] rdata_reg, rdata_next;
  timer_pkg::irq_set_t irq_reg, irq_next;
  logic out_a_reg, out_a_next;
  logic out_b_reg, out_b_next;
  logic [7:0] addr;
  logic tick, match_a, match_b, overflow;
  logic wr_cnt, wr_flags;
  logic [2:0] set_ev, clr_ev;

  // Address decode in either addressing space
  assign addr = timer_pkg::data_addr(bus_req.io_space,
                                     bus_req.addr);
  assign wr_cnt = bus_req.wr & (addr == timer_pkg::COUNT_OFS);
  assign wr_flags = bus_req.wr & (addr == timer_pkg::FLAGS_OFS);

  timer_tick u_tick (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_sel(clock_select_field_reg),
    .ext_pin(external_count_pin),
    .tick(tick)
  );

  compare_unit #(.WIDTH(WIDTH)) u_cmp_a (
    .count(counter_value_reg),
    .compare(compare_a_value_reg),
    .tick(tick),
    .suppress(block_reg),
    .match(match_a)
  );

  compare_unit #(.WIDTH(WIDTH)) u_cmp_b (
    .count(counter_value_reg),
    .compare(compare_b_value_reg),
    .tick(tick),
    .suppress(block_reg),
    .match(match_b)
  );

  // Overflow is a tick at the maximum wrapping to bottom
  assign overflow = tick &
    (counter_value_reg == WIDTH'(timer_pkg::MAX_VAL));

  // Counter and configuration registers
  always_comb
  begin
    counter_value_next = counter_value_reg;
    compare_a_value_next = compare_a_value_reg;
    compare_b_value_next = compare_b_value_reg;
    timer_irq_mask_register_next = timer_irq_mask_register_reg;
    clock_select_field_next = clock_select_field_reg;
    block_next = block_reg;
    if (tick)
    begin
      block_next = 1'b0; // Blocking lasts for one tick only
      if (overflow)
        counter_value_next = WIDTH'(timer_pkg::BOTTOM_VAL);
      else
        counter_value_next = counter_value_reg + 1'b1;
    end
    if (wr_cnt)
    begin
      // A software write beats a tick in the same cycle
      counter_value_next = bus_req.wdata[WIDTH-1:0];
      block_next = 1'b1;
    end
    if (bus_req.wr)
    begin
      case (addr)
        timer_pkg::CMPA_OFS: compare_a_value_next = bus_req.wdata[WIDTH-1:0];
        timer_pkg::CMPB_OFS: compare_b_value_next = bus_req.wdata[WIDTH-1:0];
        timer_pkg::MASK_OFS:
          timer_irq_mask_register_next = bus_req.wdata[2:0];
        timer_pkg::CLKSEL_OFS:
          clock_select_field_next = bus_req.wdata[2:0];
        default: ;
      endcase
    end
  end

  // Flags: set wins over clear so a coincident event is never lost
  always_comb
  begin
    set_ev = '0;
    set_ev[timer_pkg::OVF_BIT] = overflow;
    set_ev[timer_pkg::CMPA_BIT] = match_a;
    set_ev[timer_pkg::CMPB_BIT] = match_b;
    clr_ev = {vector_taken.cmpb, vector_taken.cmpa,
              vector_taken.ovf};
    if (wr_flags)
      clr_ev = clr_ev | bus_req.wdata[2:0];
    timer_event_flags_next = (timer_event_flags_reg & ~clr_ev) | set_ev;
  end

  // Interrupt requests, pin toggles and read data
  always_comb
  begin
    irq_next.ovf = global_irq_enable & timer_irq_mask_register_reg[0] &
                   timer_event_flags_reg[timer_pkg::OVF_BIT];
    irq_next.cmpa = global_irq_enable & timer_irq_mask_register_reg[1] &
                    timer_event_flags_reg[timer_pkg::CMPA_BIT];
    irq_next.cmpb = global_irq_enable & timer_irq_mask_register_reg[2] &
                    timer_event_flags_reg[timer_pkg::CMPB_BIT];
    // Waveform: toggle on match, the simplest non-PWM output
    out_a_next = out_a_reg ^ match_a;
    out_b_next = out_b_reg ^ match_b;
    rdata_next = rdata_reg;
    if (bus_req.rd)
    begin
      case (addr)
        timer_pkg::COUNT_OFS: rdata_next = 8'(counter_value_reg);
        timer_pkg::CMPA_OFS: rdata_next = 8'(compare_a_value_reg);
        timer_pkg::CMPB_OFS: rdata_next = 8'(compare_b_value_reg);
        timer_pkg::FLAGS_OFS: rdata_next = {5'h00, timer_event_flags_reg};
        timer_pkg::MASK_OFS: rdata_next = {5'h00, timer_irq_mask_register_reg};
        timer_pkg::CLKSEL_OFS: rdata_next = {5'h00, clock_select_field_reg};
        default: rdata_next = 8'h00; // Unmapped reads return zero
      endcase
    end
  end

  // State registers, all cleared by reset
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      counter_value_reg <= WIDTH'(timer_pkg::RESET_VAL);
      compare_a_value_reg <= WIDTH'(timer_pkg::RESET_VAL);
      compare_b_value_reg <= WIDTH'(timer_pkg::RESET_VAL);
      timer_event_flags_reg <= timer_pkg::FLAGS_RESET;
      timer_irq_mask_register_reg <= 3'h0;
      clock_select_field_reg <= 3'h0;
      block_reg <= 1'b0;
      rdata_reg <= 8'h00;
      irq_reg <= '0;
      out_a_reg <= 1'b0;
      out_b_reg <= 1'b0;
    end
    else
    begin
      counter_value_reg <= counter_value_next;
      compare_a_value_reg <= compare_a_value_next;
      compare_b_value_reg <= compare_b_value_next;
      timer_event_flags_reg <= timer_event_flags_next;
      timer_irq_mask_register_reg <= timer_irq_mask_register_next;
      clock_select_field_reg <= clock_select_field_next;
      block_reg <= block_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
    end
  end

  assign bus_rdata = rdata_reg;
  assign irq_request = irq_reg;
  assign compare_a_output_pin = out_a_reg;
  assign compare_b_output_pin = out_b_reg;

  // Reset clears the counter, the flags, the interrupt requests and the read data
  AST_RESET_ZERO: assert property (
    @(posedge clk_sys)
    sys_rst |=> counter_value_reg == '0 && timer_event_flags_reg == '0 &&
      irq_request == '0 && rdata_reg == 8'h00)
    else $error("reset left a register set");

  // Write of the counter lands on the next edge
  AST_CNT_WRITE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_cnt |=> counter_value_reg == $past(bus_req.wdata[WIDTH-1:0]))
    else $error("counter write not loaded");

  // No compare match while the write block is pending
  AST_WRITE_BLOCK: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    block_reg |-> !match_a && !match_b)
    else $error("match seen right after counter write");

  // The match wires alone would hide a channel that ignores the
  // block, so the compare flags themselves must stay put over a blocked tick
  sequence blocked_tick_s;
    block_reg && tick && !wr_flags && vector_taken == '0;
  endsequence

  AST_BLOCK_FLAGS: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    blocked_tick_s |=> timer_event_flags_reg[2:1] ==
      $past(timer_event_flags_reg[2:1]))
    else $error("blocked tick changed a compare flag");

  // A live hit on either channel: a tick that is not blocked
  sequence cmp_a_hit_s;
    tick && !block_reg && counter_value_reg == compare_a_value_reg;
  endsequence

  sequence cmp_b_hit_s;
    tick && !block_reg && counter_value_reg == compare_b_value_reg;
  endsequence

  AST_FLAG_A_SET: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    cmp_a_hit_s |=> timer_event_flags_reg[timer_pkg::CMPA_BIT])
    else $error("compare A flag not set");

  AST_FLAG_B_SET: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    cmp_b_hit_s |=> timer_event_flags_reg[timer_pkg::CMPB_BIT])
    else $error("compare B flag not set");

  AST_PIN_A: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    cmp_a_hit_s |=> compare_a_output_pin != $past(compare_a_output_pin))
    else $error("compare A pin did not toggle");

  AST_PIN_B: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    cmp_b_hit_s |=> compare_b_output_pin != $past(compare_b_output_pin))
    else $error("compare B pin did not toggle");

  AST_OVF_WRAP: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    overflow && !wr_cnt |=> counter_value_reg == '0 &&
      timer_event_flags_reg[timer_pkg::OVF_BIT])
    else $error("overflow did not wrap and flag");

  AST_W1C_A: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_flags && bus_req.wdata[1] && !match_a
    |=> !timer_event_flags_reg[timer_pkg::CMPA_BIT])
    else $error("compare A flag not cleared by one");

  AST_W1C_B: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_flags && bus_req.wdata[2] && !match_b
    |=> !timer_event_flags_reg[timer_pkg::CMPB_BIT])
    else $error("compare B flag not cleared by one");

  AST_W0_KEEP: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_flags && bus_req.wdata[2:0] == 3'h0 && vector_taken == '0
    |=> timer_event_flags_reg >= $past(timer_event_flags_reg) &&
        (timer_event_flags_reg | $past(timer_event_flags_reg))
        == timer_event_flags_reg)
    else $error("zero write changed a flag");

  AST_VEC_A: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    vector_taken.cmpa && !match_a
    |=> !timer_event_flags_reg[timer_pkg::CMPA_BIT])
    else $error("vector did not clear compare A flag");

  AST_VEC_B: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    vector_taken.cmpb && !match_b
    |=> !timer_event_flags_reg[timer_pkg::CMPB_BIT])
    else $error("vector did not clear compare B flag");

  AST_VEC_OVF: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    vector_taken.ovf && !overflow
    |=> !timer_event_flags_reg[timer_pkg::OVF_BIT])
    else $error("vector did not clear overflow flag");

  AST_IRQ_OVF: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ##1 irq_request.ovf == ($past(global_irq_enable) &&
    $past(timer_irq_mask_register_reg[0]) &&
    $past(timer_event_flags_reg[0])))
    else $error("overflow request mismatch");

  AST_STOPPED: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    clock_select_field_reg == 3'h0 && !wr_cnt
    |=> $stable(counter_value_reg))
    else $error("counter moved while stopped");
endmodule // timer_core

// >>> cpu_model.sv
// Processor core model: register bus master and interrupt vector entry.
// Assumes the timer samples strobes on the rising edge of clk_sys.
`timescale 1ns/1ns
module cpu_model
(
  // Clock
  input wire logic clk_sys,
  // Register bus
  output timer_pkg::bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  // Interrupt handshake
  output logic global_irq_enable,
  output timer_pkg::irq_set_t vector_taken
);
  // Idle bus from time zero so reset sees no strobes
  initial
  begin
    bus_req = '0;
    global_irq_enable = 1'b0;
    vector_taken = '0;
  end

  // One-cycle write strobe; counter only rewritten while stopped
  task automatic wr(input logic io, input logic [7:0] a,
                    input logic [7:0] d);
    @(negedge clk_sys);
    bus_req <= '{wr: 1'b1, rd: 1'b0, io_space: io, addr: a, wdata: d};
    @(negedge clk_sys);
    bus_req <= '0;
  endtask

  // Read data is registered, so it is taken a full cycle after the strobe
  task automatic rd(input logic io, input logic [7:0] a,
                    output logic [7:0] d);
    @(negedge clk_sys);
    bus_req <= '{wr: 1'b0, rd: 1'b1, io_space: io, addr: a, wdata: 8'h00};
    @(negedge clk_sys);
    bus_req <= '0;
    @(negedge clk_sys);
    d = bus_rdata;
  endtask

  // Vector entry lasts one cycle, as the core does
  task automatic take(input timer_pkg::irq_set_t v);
    @(negedge clk_sys);
    vector_taken <= v;
    @(negedge clk_sys);
    vector_taken <= '0;
  endtask

  // Global enable changes between instructions only
  task automatic gie(input logic v);
    @(negedge clk_sys);
    global_irq_enable <= v;
  endtask
endmodule // cpu_model

// >>> timer0_compare_and_flags_tb.sv
// Self-checking bench for the timer compare and flag block.
// Assumes cpu_model drives the bus; inputs change on the falling edge.
`timescale 1ns/1ns
module timer0_compare_and_flags_tb;
  localparam logic [7:0] FL = timer_pkg::FLAGS_OFS;
  localparam logic [7:0] CA = timer_pkg::CMPA_OFS;
  localparam logic [7:0] CB = timer_pkg::CMPB_OFS;
  localparam logic [7:0] CN = timer_pkg::COUNT_OFS;
  localparam logic [7:0] MK = timer_pkg::MASK_OFS;
  localparam logic [7:0] CS = timer_pkg::CLKSEL_OFS;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  timer_pkg::bus_req_t bus_req;
  logic [7:0] bus_rdata;
  logic global_irq_enable;
  timer_pkg::irq_set_t vector_taken;
  timer_pkg::irq_set_t irq_request;
  logic pin_a;
  logic pin_b;
  logic [7:0] rdat;
  logic ext_pin = 1'b0;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;

  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;

  // External pin is driven by the bench to test both edge modes
  timer_core #(.WIDTH(8)) u_timer_core
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .global_irq_enable(global_irq_enable),
    .vector_taken(vector_taken),
    .irq_request(irq_request),
    .external_count_pin(ext_pin),
    .compare_a_output_pin(pin_a),
    .compare_b_output_pin(pin_b)
  );

  cpu_model u_cpu_model
  (
    .clk_sys(clk_sys),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .global_irq_enable(global_irq_enable),
    .vector_taken(vector_taken)
  );

  // Summary and verdict, the only way out of the run
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Register data compare
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Interrupt request and pin compare
  task automatic check3(input logic [2:0] got, input logic [2:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Read a register and compare it
  task automatic rchk(input logic io, input logic [7:0] a,
                      input logic [7:0] exp);
    u_cpu_model.rd(io, a, rdat);
    check8(rdat, exp);
  endtask

  // Settle time for registered irq outputs
  task automatic settle();
    repeat (3) @(negedge clk_sys);
  endtask

  // Pulses on the external count pin, two cycles high and two low
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(negedge clk_sys);
      ext_pin <= 1'b1;
      repeat (2) @(negedge clk_sys);
      ext_pin <= 1'b0;
      @(negedge clk_sys);
    end
  endtask

  // Hang guard: the sequence needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      miscompares++;
      end_sim();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    // Reset values, and an unmapped place reading zero
    rchk(0, FL, 8'h00);
    rchk(0, CA, 8'h00);
    rchk(0, CB, 8'h00);
    rchk(0, CN, 8'h00);
    rchk(0, MK, 8'h00);
    rchk(0, CS, 8'h00);
    rchk(0, 8'h50, 8'h00);
    // Data-space and I/O-space views of the same registers
    u_cpu_model.wr(0, CA, 8'hA5);
    rchk(1, 8'h27, 8'hA5);
    u_cpu_model.wr(1, 8'h28, 8'h5A);
    rchk(0, CB, 8'h5A);
    u_cpu_model.wr(1, 8'h26, 8'hC3);
    rchk(0, CN, 8'hC3);
    rchk(1, 8'h15, 8'h00);
    u_cpu_model.wr(0, MK, 8'hFF);
    rchk(0, MK, 8'h07);
    // Stopped clock select holds the counter
    u_cpu_model.wr(0, CN, 8'h33);
    repeat (20) @(negedge clk_sys);
    rchk(0, CN, 8'h33);
    // A counter write hides a match on the very next tick
    u_cpu_model.wr(0, CA, 8'h40);
    u_cpu_model.wr(0, CB, 8'h01);
    u_cpu_model.wr(0, CN, 8'h40);
    u_cpu_model.wr(0, CS, 8'h01);
    repeat (3) @(negedge clk_sys);
    u_cpu_model.wr(0, CS, 8'h00);
    rchk(0, FL, 8'h00);
    // Run across both compares and the wrap from the maximum
    u_cpu_model.wr(0, CA, 8'hFE);
    u_cpu_model.wr(0, CB, 8'h02);
    u_cpu_model.wr(0, CN, 8'hFC);
    u_cpu_model.gie(1'b1);
    u_cpu_model.wr(0, CS, 8'h01);
    repeat (8) @(negedge clk_sys);
    u_cpu_model.wr(0, CS, 8'h00);
    rchk(0, FL, 8'h07);
    check3(irq_request, 3'b111);
    check3({1'b0, pin_b, pin_a}, 3'b011);
    // Writing zeros leaves flags alone; ones clear only their bits
    u_cpu_model.wr(0, FL, 8'h00);
    rchk(0, FL, 8'h07);
    u_cpu_model.wr(0, FL, 8'h04);
    rchk(0, FL, 8'h03);
    check3(irq_request, 3'b011);
    u_cpu_model.wr(1, 8'h15, 8'h02);
    rchk(0, FL, 8'h01);
    check3(irq_request, 3'b001);
    // Global enable and mask both gate the remaining request
    u_cpu_model.gie(1'b0);
    settle();
    check3(irq_request, 3'b000);
    u_cpu_model.gie(1'b1);
    settle();
    check3(irq_request, 3'b001);
    u_cpu_model.wr(0, MK, 8'h06);
    settle();
    check3(irq_request, 3'b000);
    // Vector entry clears its own flag
    u_cpu_model.take(3'b001);
    rchk(0, FL, 8'h00);
    // Divide by eight: 64 edges of this select give exactly 8 ticks
    u_cpu_model.wr(0, CA, 8'h14);
    u_cpu_model.wr(0, CB, 8'h16);
    u_cpu_model.wr(0, CN, 8'h10);
    u_cpu_model.wr(0, CS, 8'h02);
    repeat (62) @(negedge clk_sys);
    u_cpu_model.wr(0, CS, 8'h00);
    rchk(0, CN, 8'h18);
    rchk(0, FL, 8'h06);
    check3(irq_request, 3'b110);
    check3({1'b0, pin_b, pin_a}, 3'b000);
    // Vector entry clears the compare flags as well
    u_cpu_model.take(3'b110);
    rchk(0, FL, 8'h00);
    check3(irq_request, 3'b000);
    // External pin: three rising edges, then three falling edges
    u_cpu_model.wr(0, CN, 8'h20);
    u_cpu_model.wr(0, CS, 8'h07);
    pulse(3);
    u_cpu_model.wr(0, CS, 8'h06);
    pulse(3);
    u_cpu_model.wr(0, CS, 8'h00);
    rchk(0, CN, 8'h26);
    // A second reset in mid-run clears everything again
    @(negedge clk_sys);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    rchk(0, CN, 8'h00);
    rchk(0, MK, 8'h00);
    rchk(0, CA, 8'h00);
    check3(irq_request, 3'b000);
    end_sim();
  end
endmodule // timer0_compare_and_flags_tb
